// [src/sarseq_top.sv]
// Sequencer for an eight-channel 8-bit successive-approximation converter.
// Assumes an APB master on core_clk and an analog front end that answers the
// tap code with one comparator bit; the trigger and comparator are asynchronous.
// Function
// - Result is rounded input over reference times 256
// - Only the selected one of eight channels converts
// - Hardware mode waits then starts on trigger edge
// - Hardware mode: store, interrupt, wait fresh edge
// - Hardware mode channel write aborts, waits trigger
// - Hardware mode channel write in standby: no start
// - Hardware mode enable rewrite discards, waits trigger
// - Clearing enable halts conversion at once
// - Software mode starts without any trigger
// - Software mode stores, interrupts, restarts continuously
// - Software mode channel write restarts new channel
// - Software mode enable rewrite restarts immediately
// - Result read beats simultaneous result write
// - Trigger edges ignored during conversion and write
// - Register write beats result write, no interrupt
// - Standby or disable stops converter and string
// - Resolution eight bits, step is 1/256
// - Conversion interval includes the sampling phase
// - Edge select: none, fall, rise, both
// - Bits decided from 7 down to 0
// - Time select gives 144/20 down to 48/6
// - Channel register three bits, upper zero, reset 0
`timescale 1ns/10ps
module sarseq_top (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_trigger_in,
    input wire logic comparator_in,
    input wire logic standby_in,
    output logic [2:0] channel_sel_out,
    output logic sample_hold_out,
    output logic [7:0] tap_code_out,
    output logic string_power_out,
    output logic conversion_done_irq
);
    import sarseq_pkg::*;

    // ----------
    // Registers and state
    // ----------
    // Plain flip-flops, synchronous reset only
    logic [7:0] converter_mode_reg; // Enable, trigger select, time, edge
    logic [7:0] channel_select_reg; // Channel code in low three bits
    logic [7:0] conversion_result_reg; // Last stored result
    logic [7:0] sar_reg; // Approximation in progress
    logic [7:0] count_reg; // Cycles left in current phase
    logic [2:0] bit_reg; // Bit under decision
    logic pend_reg; // Finished result held back by a read
    logic [7:0] pend_val_reg; // Value held back
    sarseq_state_t state_reg;
    logic [2:0] trig_sync_reg; // Two sync stages plus last value
    logic [1:0] comp_sync_reg; // Comparator synchroniser
    logic [1:0] stby_sync_reg; // Standby request synchroniser

    // ----------
    // Bus decode
    // ----------
    // Writes land at the access edge
    logic acc; // Access phase completes this cycle
    logic wr_mode; // Mode register written
    logic wr_chan; // Channel register written
    logic rd_rslt; // Result register read
    logic mapped; // Address hits a register
    assign acc = psel && penable && pready;
    assign mapped = (paddr == SARSEQ_MODE_OFS) || (paddr == SARSEQ_CHAN_OFS) ||
                    (paddr == SARSEQ_RSLT_OFS) || (paddr == SARSEQ_STAT_OFS);
    assign wr_mode = acc && pwrite && (paddr == SARSEQ_MODE_OFS);
    assign wr_chan = acc && pwrite && (paddr == SARSEQ_CHAN_OFS);
    assign rd_rslt = acc && !pwrite && (paddr == SARSEQ_RSLT_OFS);

    // ----------
    // Input synchronisers and edge detect
    // ----------
    // Pins are asynchronous to core_clk
    // Only the second stage, and the trigger's last value, is looked at by logic
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            trig_sync_reg <= 3'h0;
            comp_sync_reg <= 2'h0;
            stby_sync_reg <= 2'h0;
        end else begin
            trig_sync_reg <= {trig_sync_reg[1], trig_sync_reg[0], ext_trigger_in};
            comp_sync_reg <= {comp_sync_reg[0], comparator_in};
            stby_sync_reg <= {stby_sync_reg[0], standby_in};
        end
    end

    logic trig_rise; // Rising edge seen on synchronised trigger
    logic trig_fall; // Falling edge seen on synchronised trigger
    logic trig_hit; // Edge of the selected kind
    logic standby; // Synchronised standby
    assign trig_rise = trig_sync_reg[1] && !trig_sync_reg[2];
    assign trig_fall = !trig_sync_reg[1] && trig_sync_reg[2];
    assign standby = stby_sync_reg[1];
    always_comb begin
        // Edge select decode: 00 none, 01 fall, 10 rise, 11 both
        case (converter_mode_reg[SARSEQ_EDGE_HI:SARSEQ_EDGE_LO])
            2'b01: trig_hit = trig_fall;
            2'b10: trig_hit = trig_rise;
            2'b11: trig_hit = trig_rise || trig_fall;
            default: trig_hit = 1'b0;
        endcase
    end

    // ----------
    // Conversion timing from the time select field
    // ----------
    // Lengths in core_clk cycles
    logic [7:0] conv_len; // Total cycles, sampling included
    logic [7:0] samp_len; // Sampling cycles
    logic [7:0] step_len; // Cycles per approximation step
    always_comb begin
        // Prohibited codes fall back to the slowest setting
        case (converter_mode_reg[SARSEQ_TSEL_HI:SARSEQ_TSEL_LO])
            3'b001: begin
                conv_len = SARSEQ_CONV_120;
                samp_len = SARSEQ_SAMP_16;
            end
            3'b010: begin
                conv_len = SARSEQ_CONV_96;
                samp_len = SARSEQ_SAMP_12;
            end
            3'b100: begin
                conv_len = SARSEQ_CONV_72;
                samp_len = SARSEQ_SAMP_10;
            end
            3'b101: begin
                conv_len = SARSEQ_CONV_60;
                samp_len = SARSEQ_SAMP_8;
            end
            3'b110: begin
                conv_len = SARSEQ_CONV_48;
                samp_len = SARSEQ_SAMP_6;
            end
            default: begin
                conv_len = SARSEQ_CONV_144;
                samp_len = SARSEQ_SAMP_20;
            end
        endcase
        // Remainder split over eight steps, truncated; only the 120-cycle code divides exactly
        step_len = 8'((conv_len - samp_len) >> 3);
    end

    // ----------
    // Control decisions
    // ----------
    // Mode writes act in their own cycle
    logic enable; // Enable bit after any write this cycle
    logic hw_mode; // Hardware trigger selected
    logic busy; // Sampling or approximating
    logic restart; // Write that aborts the running conversion
    logic finish; // Last step ends this cycle
    logic [7:0] final_code; // Code with last bit decided
    logic store; // Result write really happens
    assign enable = wr_mode ? pwdata[SARSEQ_ENABLE_BIT] : converter_mode_reg[SARSEQ_ENABLE_BIT];
    assign hw_mode = wr_mode ? pwdata[SARSEQ_HWTRIG_BIT] : converter_mode_reg[SARSEQ_HWTRIG_BIT];
    assign busy = (state_reg == SARSEQ_SAMPLE) || (state_reg == SARSEQ_APPROX);
    // Any channel write or rewrite of the enable bit restarts
    assign restart = wr_chan || wr_mode;
    assign finish = (state_reg == SARSEQ_APPROX) && (count_reg == 8'h01) && (bit_reg == 3'h0);
    // Bit kept when input is at or above the tap
    assign final_code = comp_sync_reg[1] ? sar_reg : (sar_reg & 8'hFE);
    // Register writes pre-empt the result write and its pulse
    assign store = finish && !restart && !standby && enable;

    // ----------
    // Sequencer state machine
    // ----------
    // Each phase counts down to one
    // Disable and standby beat all else
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_reg <= SARSEQ_IDLE;
            sar_reg <= 8'h00;
            count_reg <= 8'h00;
            bit_reg <= 3'h0;
        end else if (standby || !enable) begin
            // Stops at once, string unpowered
            state_reg <= SARSEQ_IDLE;
            sar_reg <= 8'h00;
        end else if (restart || state_reg == SARSEQ_IDLE) begin
            // Fresh start: hardware mode waits for an edge
            if (hw_mode) begin
                state_reg <= SARSEQ_WAIT_TRIG;
            end else begin
                state_reg <= SARSEQ_SAMPLE;
                count_reg <= samp_len;
            end
        end else begin
            case (state_reg)
                SARSEQ_WAIT_TRIG: begin
                    // Edges only count here, never while busy
                    if (trig_hit) begin
                        state_reg <= SARSEQ_SAMPLE;
                        count_reg <= samp_len;
                    end
                end
                SARSEQ_SAMPLE: begin
                    if (count_reg == 8'h01) begin
                        // Trial with top bit set
                        state_reg <= SARSEQ_APPROX;
                        sar_reg <= 8'h80;
                        bit_reg <= 3'h7;
                        count_reg <= step_len;
                    end else begin
                        count_reg <= count_reg - 8'h01;
                    end
                end
                SARSEQ_APPROX: begin
                    if (count_reg != 8'h01) begin
                        count_reg <= count_reg - 8'h01;
                    end else if (bit_reg != 3'h0) begin
                        // Decide this bit, then try the next lower one
                        sar_reg <= (comp_sync_reg[1] ? sar_reg : (sar_reg & ~(8'h01 << bit_reg)))
                                   | (8'h01 << (bit_reg - 3'h1));
                        bit_reg <= bit_reg - 3'h1;
                        count_reg <= step_len;
                    end else if (hw_mode) begin
                        // One shot per edge
                        state_reg <= SARSEQ_WAIT_TRIG;
                    end else begin
                        // Repeat at once
                        state_reg <= SARSEQ_SAMPLE;
                        count_reg <= samp_len;
                    end
                end
                default: state_reg <= SARSEQ_IDLE;
            endcase
        end
    end

    // ----------
    // Mode and channel registers
    // ----------
    // Software writes only
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            converter_mode_reg <= SARSEQ_MODE_RST;
            channel_select_reg <= SARSEQ_CHAN_RST;
        end else begin
            if (wr_mode) begin
                converter_mode_reg <= pwdata[7:0];
            end
            if (wr_chan) begin
                // Upper bits always zero
                channel_select_reg <= {5'h00, pwdata[SARSEQ_CHAN_W-1:0]};
            end
        end
    end

    // ----------
    // Result register with read priority
    // ----------
    // Pulse and write share one edge
    // Held value waits one cycle at most
    // A read in the store cycle returns the old value; the new one lands next cycle
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            conversion_result_reg <= SARSEQ_RSLT_RST;
            pend_reg <= 1'b0;
            pend_val_reg <= 8'h00;
            conversion_done_irq <= 1'b0;
        end else begin
            conversion_done_irq <= 1'b0;
            if (store && rd_rslt) begin
                pend_reg <= 1'b1;
                pend_val_reg <= final_code;
            end else if (store) begin
                conversion_result_reg <= final_code;
                conversion_done_irq <= 1'b1;
            end else if (pend_reg) begin
                conversion_result_reg <= pend_val_reg;
                conversion_done_irq <= 1'b1;
                pend_reg <= 1'b0;
            end
        end
    end

    // ----------
    // APB slave: zero wait states, error on unmapped address
    // ----------
    // Read data captured in setup
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            // Ready is raised in setup so the access phase lasts one cycle
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    SARSEQ_MODE_OFS: prdata <= {24'h000000, converter_mode_reg};
                    SARSEQ_CHAN_OFS: prdata <= {24'h000000, channel_select_reg};
                    SARSEQ_RSLT_OFS: prdata <= {24'h000000, conversion_result_reg};
                    SARSEQ_STAT_OFS: prdata <= {28'h0000000, pend_reg, busy, 2'(state_reg)};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ----------
    // Analog front end drive
    // ----------
    // Registered for a clean analog edge
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            channel_sel_out <= 3'h0;
            sample_hold_out <= 1'b0;
            tap_code_out <= 8'h00;
            string_power_out <= 1'b0;
        end else begin
            channel_sel_out <= channel_select_reg[SARSEQ_CHAN_W-1:0];
            sample_hold_out <= (state_reg == SARSEQ_SAMPLE);
            tap_code_out <= sar_reg;
            string_power_out <= converter_mode_reg[SARSEQ_ENABLE_BIT] && !standby;
        end
    end
endmodule // sarseq_top

// [src/sarseq_pkg.sv]
// Package for the eight-channel 8-bit SAR converter sequencer.
// Assumes an APB slave with 32-bit data and one aligned word per register.
package sarseq_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] SARSEQ_MODE_OFS = 8'h00; // Mode register
    localparam logic [7:0] SARSEQ_CHAN_OFS = 8'h04; // Channel select register
    localparam logic [7:0] SARSEQ_RSLT_OFS = 8'h08; // Conversion result register
    localparam logic [7:0] SARSEQ_STAT_OFS = 8'h0C; // Sequencer status register
    // ------------------------------------------------------------
    // Mode register fields
    // ------------------------------------------------------------
    localparam int SARSEQ_ENABLE_BIT = 7;    // Conversion enable
    localparam int SARSEQ_HWTRIG_BIT = 6;    // Hardware trigger select
    localparam int SARSEQ_TSEL_HI = 5;       // Conversion time select, top bit
    localparam int SARSEQ_TSEL_LO = 3;       // Conversion time select, low bit
    localparam int SARSEQ_EDGE_HI = 2;       // Trigger edge select, high bit
    localparam int SARSEQ_EDGE_LO = 1;       // Trigger edge select, low bit
    localparam int SARSEQ_CHAN_W = 3;        // Channel code width
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] SARSEQ_MODE_RST = 8'h00;
    localparam logic [7:0] SARSEQ_CHAN_RST = 8'h00;
    localparam logic [7:0] SARSEQ_RSLT_RST = 8'h00;
    // ------------------------------------------------------------
    // Timing counts in main clock cycles per time select code
    // ------------------------------------------------------------
    localparam logic [7:0] SARSEQ_CONV_144 = 8'd144;
    localparam logic [7:0] SARSEQ_CONV_120 = 8'd120;
    localparam logic [7:0] SARSEQ_CONV_96 = 8'd96;
    localparam logic [7:0] SARSEQ_CONV_72 = 8'd72;
    localparam logic [7:0] SARSEQ_CONV_60 = 8'd60;
    localparam logic [7:0] SARSEQ_CONV_48 = 8'd48;
    localparam logic [7:0] SARSEQ_SAMP_20 = 8'd20;
    localparam logic [7:0] SARSEQ_SAMP_16 = 8'd16;
    localparam logic [7:0] SARSEQ_SAMP_12 = 8'd12;
    localparam logic [7:0] SARSEQ_SAMP_10 = 8'd10;
    localparam logic [7:0] SARSEQ_SAMP_8 = 8'd8;
    localparam logic [7:0] SARSEQ_SAMP_6 = 8'd6;
    localparam logic [7:0] SARSEQ_NBITS = 8'd8;
    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SARSEQ_IDLE,
        SARSEQ_WAIT_TRIG,
        SARSEQ_SAMPLE,
        SARSEQ_APPROX
    } sarseq_state_t;
endpackage

// [verification/sarseq_monitor.sv]
// Port checker for the sequencer.
// Assumes a bind into sarseq_top.
`timescale 1ns/10ps
module sarseq_monitor (
    input logic core_clk,
    input logic sys_rst,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    input logic standby_in,
    input logic [2:0] channel_sel_out,
    input logic sample_hold_out,
    input logic [7:0] tap_code_out,
    input logic string_power_out,
    input logic conversion_done_irq
);
    import sarseq_pkg::*;
    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    logic acc; // Access phase of a transfer
    logic mwr; // Committed mode or channel write
    logic [7:0] samp_cnt; // Length of the running sample phase
    assign acc = psel && penable;
    assign mwr = acc && pready && pwrite && (paddr == SARSEQ_MODE_OFS || paddr == SARSEQ_CHAN_OFS);
    // Counts sampled-high cycles; cleared when sampling ends
    always_ff @(posedge core_clk) begin
        if (sys_rst || !sample_hold_out) begin
            samp_cnt <= 8'h00;
        end else begin
            samp_cnt <= samp_cnt + 8'h01;
        end
    end
    logic cut; // Sampling cut short by a write
    always_ff @(posedge core_clk) begin
        if (sys_rst || (!sample_hold_out && !mwr)) begin
            cut <= 1'b0;
        end else if (mwr) begin
            cut <= 1'b1;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_irq_pulse; conversion_done_irq |=> !conversion_done_irq; endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("done pulse too long");
    property p_pready; psel && !penable |=> pready; endproperty
    a_pready: assert property (p_pready) else $error("no ready after setup");
    property p_unmapped; pready && paddr > SARSEQ_STAT_OFS |-> pslverr && prdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_upper; pready && !pwrite |-> prdata[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    // Register write beats a store
    property p_write_wins; mwr |=> !conversion_done_irq [*8]; endproperty
    a_write_wins: assert property (p_write_wins) else $error("done after write");
    property p_irq_powered; conversion_done_irq |-> string_power_out; endproperty
    a_irq_powered: assert property (p_irq_powered) else $error("done while halted");
    // Sync delay plus margin
    property p_standby; standby_in [*6] |-> !string_power_out && !sample_hold_out; endproperty
    a_standby: assert property (p_standby) else $error("running in standby");
    property p_samp_len;
        $fell(sample_hold_out) && string_power_out && !cut |-> samp_cnt inside {8'h06, 8'h08, 8'h0A, 8'h0C, 8'h10, 8'h14};
    endproperty
    a_samp_len: assert property (p_samp_len) else $error("bad sample length");
    property p_msb_first; $fell(sample_hold_out) && string_power_out && !cut |-> ##[0:2] tap_code_out == 8'h80; endproperty
    a_msb_first: assert property (p_msb_first) else $error("first trial not mid scale");
    property p_chan_stable; sample_hold_out && !$past(acc) && !$past(acc, 2) |-> $stable(channel_sel_out); endproperty
    a_chan_stable: assert property (p_chan_stable) else $error("channel moved while sampling");
endmodule // sarseq_monitor

bind sarseq_top sarseq_monitor u_mon (.*);

// [verification/sarseq_afe_model.sv]
// Analog front end: channel mux, sample/hold and comparator on the string tap.
// Assumes inputs in half-step units (1/512 of reference) from the bench.
`timescale 1ns/10ps
module sarseq_afe_model (
    input wire logic core_clk,
    input wire logic [2:0] channel_sel_out,
    input wire logic sample_hold_out,
    input wire logic [7:0] tap_code_out,
    input wire logic string_power_out,
    input wire logic [7:0][8:0] vin,
    output logic comparator_in
);
    logic [8:0] held = 9'h000; // Held input voltage
    logic junk = 1'b0; // Toggles so an unpowered string gives no steady answer
    // Follow the selected pin while sampling, then hold
    always_ff @(posedge core_clk) begin
        if (sample_hold_out) begin
            held <= vin[channel_sel_out];
        end
        junk <= !junk;
    end
    // Input >= tap minus half a step gives the rounded code
    always_comb begin
        if (!string_power_out) begin
            comparator_in = junk;
        end else begin
            comparator_in = ({1'b0, held} + 10'h001) >= {1'b0, tap_code_out, 1'b0};
        end
    end
endmodule // sarseq_afe_model

// [verification/sarseq_tb_top.sv]
// Bench for the SAR sequencer: APB master tasks, analog model, scenarios.
// Assumes the design, analog model and monitor are compiled first.
`timescale 1ns/10ps
module sarseq_tb_top;
    import sarseq_pkg::*;
    // ------------------------------------------------------------
    // Signals and bench state
    // ------------------------------------------------------------
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ext_trigger_in = 1'b0, standby_in = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, comparator_in, sample_hold_out, string_power_out, conversion_done_irq, er;
    logic [2:0] channel_sel_out, ch;
    logic [7:0] tap_code_out;
    logic [7:0][8:0] vin; // Channel inputs, half-step units
    int seed = 32'hB56C;
    int n_mismatch = 0, compares = 0, cycles = 0, irq_cnt = 0, irq_at = 0, irq_gap = 0;
    int samp_run = 0, samp_len = 0, n = 0, t = 0;
    int conv_t [6] = '{144, 120, 96, 72, 60, 48}; // Clocks per conversion
    int samp_t [6] = '{20, 16, 12, 10, 8, 6}; // Sampling clocks
    sarseq_top u_dut (.*);
    sarseq_afe_model u_afe (.*);
    initial begin
        forever #4 core_clk = !core_clk;
    end
    // Timeout, done-pulse stamps and sample run length
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        samp_run <= sample_hold_out ? samp_run + 1 : 0;
        if (!sample_hold_out && samp_run != 0) samp_len <= samp_run;
        if (conversion_done_irq === 1'b1) begin
            irq_cnt <= irq_cnt + 1;
            irq_gap <= cycles - irq_at;
            irq_at <= cycles;
        end
        if (cycles == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end
    // ------------------------------------------------------------
    // Expectations and tasks
    // ------------------------------------------------------------
    function automatic logic [31:0] exp_code(input logic [8:0] v);
        return {23'h0, 9'(v + 9'h001) >> 1};
    endfunction
    // Integer step length truncates the nominal total
    function automatic int step_total(input int i);
        return samp_t[i] + 8 * ((conv_t[i] - samp_t[i]) / 8);
    endfunction
    function automatic int edge_hits(input int e);
        return (e == 0) ? 0 : ((e == 3) ? 2 : 1);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One transfer; holds everything until ready, then one idle edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic wait_irq(input int m);
        while (irq_cnt < n + m) begin
            @(posedge core_clk);
        end
    endtask
    task automatic trig(input logic v, input int m);
        ext_trigger_in <= v;
        repeat (m) @(posedge core_clk);
    endtask
    task automatic complete_run();
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        for (int i = 0; i < 8; i++) vin[i] = 9'({$random(seed)} % 510);
        vin[0] = 9'h000; // Bottom code
        vin[1] = 9'h001; // Half a step rounds up
        vin[7] = 9'h1FD; // Top code
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        rdchk(SARSEQ_MODE_OFS, 32'h0);
        rdchk(SARSEQ_CHAN_OFS, 32'h0);
        rdchk(SARSEQ_RSLT_OFS, 32'h0);
        rdchk(8'h10, 32'h0);
        chk({31'h0, er}, 32'h1);
        apb(1'b1, SARSEQ_CHAN_OFS, 32'hFFFFFFFF);
        rdchk(SARSEQ_CHAN_OFS, 32'h7);
        // Software start over the six permitted time codes, random channel
        for (int i = 0; i < 6; i++) begin
            ch = 3'($random(seed));
            apb(1'b1, SARSEQ_MODE_OFS, 32'h0);
            apb(1'b1, SARSEQ_CHAN_OFS, {29'h0, ch});
            n = irq_cnt;
            apb(1'b1, SARSEQ_MODE_OFS, 32'h80 | ((i + (i > 2)) << 3));
            wait_irq(2);
            chk(samp_len, samp_t[i]);
            chk(32'(irq_gap >= step_total(i) && irq_gap <= conv_t[i] + 3), 32'h1);
            rdchk(SARSEQ_RSLT_OFS, exp_code(vin[ch]));
        end
        repeat (30) @(posedge core_clk);
        apb(1'b1, SARSEQ_CHAN_OFS, 32'h7);
        n = irq_cnt;
        wait_irq(1);
        rdchk(SARSEQ_RSLT_OFS, exp_code(vin[7]));
        repeat (20) @(posedge core_clk);
        t = cycles;
        apb(1'b1, SARSEQ_MODE_OFS, 32'hB0);
        n = irq_cnt;
        wait_irq(1);
        chk(32'(irq_at - t >= 46 && irq_at - t <= 56), 32'h1);
        repeat (20) @(posedge core_clk);
        apb(1'b1, SARSEQ_MODE_OFS, 32'h0);
        n = irq_cnt;
        repeat (200) @(posedge core_clk);
        chk(irq_cnt - n, 0);
        chk({string_power_out, sample_hold_out}, 32'h0);
        apb(1'b1, SARSEQ_MODE_OFS, 32'hB0);
        standby_in <= 1'b1;
        n = irq_cnt;
        repeat (200) @(posedge core_clk);
        chk(irq_cnt - n, 0);
        chk({31'h0, string_power_out}, 32'h0);
        standby_in <= 1'b0;
        apb(1'b1, SARSEQ_MODE_OFS, 32'h0);
        // Hardware start with every edge code
        for (int e = 0; e < 4; e++) begin
            n = irq_cnt;
            apb(1'b1, SARSEQ_MODE_OFS, 32'hF0 | (e << 1));
            repeat (100) @(posedge core_clk);
            apb(1'b1, SARSEQ_CHAN_OFS, {29'h0, 3'(e)});
            trig(1'b0, 100);
            chk(irq_cnt - n, 0);
            trig(1'b1, 100);
            trig(1'b0, 100);
            chk(irq_cnt - n, edge_hits(e));
            if (e != 0) rdchk(SARSEQ_RSLT_OFS, exp_code(vin[e]));
        end
        n = irq_cnt;
        apb(1'b1, SARSEQ_MODE_OFS, 32'hF4);
        trig(1'b1, 20);
        apb(1'b1, SARSEQ_CHAN_OFS, 32'h5);
        trig(1'b1, 100);
        chk(irq_cnt - n, 0);
        trig(1'b0, 10);
        trig(1'b1, 10);
        trig(1'b0, 10);
        trig(1'b1, 100);
        chk(irq_cnt - n, 1);
        rdchk(SARSEQ_RSLT_OFS, exp_code(vin[5]));
        trig(1'b0, 10);
        n = irq_cnt;
        trig(1'b1, 20);
        apb(1'b1, SARSEQ_MODE_OFS, 32'hF4);
        trig(1'b1, 100);
        chk(irq_cnt - n, 0);
        trig(1'b0, 10);
        trig(1'b1, 100);
        chk(irq_cnt - n, 1);
        complete_run();
    end
endmodule // sarseq_tb_top
